// ---- sim/hbl_chk_asserts.sv ----
`timescale 1ns/1ps
module hbl_chk (input wire ref_clk, rstn, host_reset, cycle_strobe_n, burst_ready_n, sys_access_r,
  input wire next_word_req_r, seq_active_r, input wire [3:0] latch_close_r, input wire [1:0] seq_pos_r);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence idle; burst_ready_n || cycle_strobe_n; endsequence
  a_req_taken: assert property (not (idle ##1 next_word_req_r)) else $error("stray req");
  a_req_active: assert property (next_word_req_r |-> seq_active_r) else $error("req idle");
  a_close_onehot: assert property (|latch_close_r |-> $onehot(latch_close_r)) else $error("multi close");
  a_sys_quiet: assert property (sys_access_r |-> !latch_close_r) else $error("close in sys");
  a_sys_taken: assert property (not (idle ##1 $rose(sys_access_r))) else $error("stray sys");
  a_pos_step: assert property (seq_active_r && $past(seq_active_r) && $changed(seq_pos_r) |->
    seq_pos_r == $past(seq_pos_r) + 2'h1) else $error("pos jump");
  a_reset_idle: assert property (host_reset |=> !seq_active_r && !seq_pos_r) else $error("not idle");
  a_strobe_end: assert property ($rose(cycle_strobe_n) |-> ##2 !seq_active_r && !sys_access_r) else $error("open");
endmodule // hbl_chk
bind hbl_seq hbl_chk u_chk (.*);

// ---- sim/hbl_host.sv ----
`timescale 1ns/1ps
module hbl_host (input wire ref_clk, output reg cycle_strobe_n = 1, burst_ready_n = 1,
  output reg [1:0] interleave = 0, start_sel = 0, output reg [15:0] host_data_bus = 0);
  task burst(input [1:0] f, s, input [3:0] n);
    @(negedge ref_clk) {cycle_strobe_n, interleave, start_sel} = {1'b0, f, s};
    // one ready per word, data valid with it; interleave flips after the first word
    for (int k = 0; k < n; k++)
      @(negedge ref_clk) {burst_ready_n, interleave, host_data_bus} = {1'b0, k ? ~f : f, 8'h0, f, s, k[3:0]};
    // released bus shows the inverse, never a stale word
    @(negedge ref_clk) {burst_ready_n, host_data_bus} = {1'b1, ~host_data_bus};
    repeat (4) @(negedge ref_clk);
    cycle_strobe_n = 1;
  endtask
endmodule // hbl_host

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb;
  reg ref_clk = 0, rstn = 0, host_reset = 0, clock_ratio_strap = 1, write_cycle = 1, latch_ready = 1;
  reg [1:0] cf, cs;
  wire cycle_strobe_n, burst_ready_n, sys_access_r, next_word_req_r, seq_active_r, op_phase_r, fifo_ready_r;
  wire [1:0] interleave, start_sel, seq_pos_r;
  wire [3:0] latch_close_r;
  wire [15:0] host_data_bus, latch_data_r;
  integer error_cnt = 0, compares = 0, nl = 0, nr = 0;
  hbl_host host (.*);
  hbl_seq DUT (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  task chk(input string nm, input [15:0] e, g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  always @(negedge ref_clk) begin
    if (next_word_req_r) nr++;
    if (|latch_close_r) begin
      chk("latch", 16'h1 << (cf[0] ? {cs[1], cs[0] ^ nl[0]} : cf[1] ? cs : cs ^ nl[1:0]), latch_close_r);
      chk("data", {8'h0, cf, cs, 2'h0, nl[1:0]}, latch_data_r);
      nl++;
    end
  end
  task t_write;
    for (int f = 0; f < 16; f++) begin
      {cf, cs} = f;
      nl = 0;
      host.burst(cf, cs, 5);
      chk("count", cf == 3 ? 0 : 4, nl);
      chk("sys", cf == 3, sys_access_r);
      chk("pos", cf == 3 ? 0 : 3, seq_pos_r);
      chk("op full", 1, op_phase_r);
    end
    $display("write orders done");
  endtask
  task t_fifo;
    {cf, cs, nl, latch_ready} = 0;
    fork
      host.burst(0, 0, 4);
      begin
        repeat (5) @(negedge ref_clk);
        chk("held", 0, nl);
        chk("fifo ready", 1, fifo_ready_r);
        latch_ready = 1;
      end
    join
    chk("drained", 4, nl);
    $display("fifo done");
  endtask
  task t_half;
    #25 host_reset = 1;
    #25 {rstn, host_reset, clock_ratio_strap, write_cycle, nr} = 0;
    chk("idle", 0, seq_active_r);
    #50 rstn = 1;
    host.burst(0, 0, 4);
    chk("half rate", 2, nr);
    nl = op_phase_r;
    @(negedge ref_clk);
    chk("op toggle", !nl[0], op_phase_r);
    $display("half rate done");
  endtask
  task final_report;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #300 rstn = 1;
    repeat (2) @(negedge ref_clk);
    t_write;
    t_fifo;
    t_half;
    final_report;
  end
endmodule // tb

// ---- verilog/hbl_regs.vh ----
`ifndef HBL_REGS_VH
`define HBL_REGS_VH
`define HBL_DATA_W 16
`define HBL_FIFO_DEPTH 16
`define HBL_FIFO_AW 4
`define HBL_IF_FOUR 2'h0
`define HBL_IF_TWO 2'h1
`define HBL_IF_ONE 2'h2
`define HBL_IF_SYS 2'h3
`define HBL_LAST_POS 2'h3
`endif

// ---- verilog/hbl_seq.v ----
`timescale 1ns/1ps
`include "hbl_regs.vh"

module hbl_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire ref_clk,
  input wire rstn,
  input wire clr,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_r;
  reg [AW:0] rd_r;
  wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  wire empty = (wr_r == rd_r);
  wire push = in_valid && !full;
  wire pop = out_valid && out_ready;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_r[AW-1:0]];
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end
  always @(posedge ref_clk) begin
    if (!rstn || clr) begin
      wr_r <= {(AW+1){1'b0}};
      rd_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule // hbl_fifo

module hbl_seq (
  input wire ref_clk,
  input wire rstn,
  input wire host_reset,
  input wire clock_ratio_strap,
  input wire cycle_strobe_n,
  input wire burst_ready_n,
  input wire write_cycle,
  input wire [1:0] interleave,
  input wire [1:0] start_sel,
  input wire [15:0] host_data_bus,
  input wire latch_ready,
  output reg [3:0] latch_close_r,
  output reg [15:0] latch_data_r,
  output reg sys_access_r,
  output reg next_word_req_r,
  output reg seq_active_r,
  output reg [1:0] seq_pos_r,
  output reg op_phase_r,
  output reg fifo_ready_r
);
  reg strap_r;
  reg strap_taken_r;
  reg div_r;
  reg strobe_d_r;
  reg [1:0] if_r;
  reg [1:0] sel_r;
  reg done_r;
  reg [1:0] pos_nxt;
  reg [1:0] lat_nxt;
  wire fifo_in_ready;
  wire [17:0] fifo_out_data;
  wire fifo_out_valid;
  wire [3:0] close_sel;
  wire strap_now = strap_taken_r ? strap_r : clock_ratio_strap;
  // 2x clock halves to operating phase
  wire op_edge = strap_now | div_r;
  wire cyc_end = !strobe_d_r && cycle_strobe_n;
  wire kill = !rstn || host_reset || cyc_end;
  // words of an ended cycle are dropped with it
  wire fifo_clr = host_reset || cyc_end;
  wire rdy = op_edge && !burst_ready_n && !cycle_strobe_n;
  wire first = rdy && !seq_active_r;
  wire [1:0] eff_if = first ? interleave : if_r;
  wire [1:0] eff_sel = first ? start_sel : sel_r;
  wire [1:0] pos_use = first ? 2'h0 : pos_nxt;
  wire take = rdy && !done_r && (eff_if != `HBL_IF_SYS);
  wire wr_push = take && write_cycle;
  always @* begin
    pos_nxt = seq_pos_r + 2'h1;
    case (eff_if)
      `HBL_IF_FOUR: lat_nxt = eff_sel ^ pos_use;
      `HBL_IF_TWO: lat_nxt = {eff_sel[1], eff_sel[0] ^ pos_use[0]};
      `HBL_IF_ONE: lat_nxt = eff_sel;
      default: lat_nxt = 2'h0;
    endcase
  end
  hbl_fifo #(.WIDTH(18), .DEPTH(`HBL_FIFO_DEPTH), .AW(`HBL_FIFO_AW)) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clr(fifo_clr),
    .in_data({lat_nxt, host_data_bus}),
    .in_valid(wr_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(latch_ready)
  );
  always @(posedge ref_clk) begin
    if (!rstn) begin
      strap_r <= 1'b1;
      strap_taken_r <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_r <= clock_ratio_strap;
      strap_taken_r <= 1'b1;
    end
  end
  always @(posedge ref_clk) begin
    if (!rstn) begin
      div_r <= 1'b0;
    end else begin
      div_r <= strap_now ? 1'b0 : ~div_r;
    end
  end
  always @(posedge ref_clk) begin
    // starts high so release gives no false cycle end
    if (!rstn) begin
      strobe_d_r <= 1'b1;
    end else begin
      strobe_d_r <= cycle_strobe_n;
    end
  end
  // one select line per write latch
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_close
      assign close_sel[gi] = ({30'h0, fifo_out_data[17:16]} == gi);
    end
  endgenerate
  always @(posedge ref_clk) begin
    latch_close_r <= 4'h0;
    if (!rstn) begin
      op_phase_r <= 1'b0;
      fifo_ready_r <= 1'b0;
      latch_data_r <= 16'h0000;
    end else begin
      op_phase_r <= op_edge;
      fifo_ready_r <= fifo_in_ready;
      latch_data_r <= fifo_out_data[15:0];
      // one latch closes per drained word
      if (fifo_out_valid && latch_ready) begin
        latch_close_r <= close_sel;
      end
    end
  end
  always @(posedge ref_clk) begin
    if (kill) begin
      seq_active_r <= 1'b0;
      if_r <= 2'h0;
      sel_r <= 2'h0;
      sys_access_r <= 1'b0;
    end else if (first) begin
      seq_active_r <= 1'b1;
      if_r <= interleave;
      sel_r <= start_sel;
      sys_access_r <= (interleave == `HBL_IF_SYS);
    end
  end
  always @(posedge ref_clk) begin
    if (kill) begin
      next_word_req_r <= 1'b0;
    end else begin
      next_word_req_r <= take && !write_cycle;
    end
  end
  always @(posedge ref_clk) begin
    if (kill) begin
      seq_pos_r <= 2'h0;
      done_r <= 1'b0;
    end else begin
      // advance, stop after fourth
      // a full fifo holds the position; the host must watch fifo_ready_r
      if (take && (!write_cycle || fifo_in_ready)) begin
        seq_pos_r <= pos_use;
        if (pos_use == `HBL_LAST_POS) begin
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule // hbl_seq
